// ==== hw/qcc_defs.vh ====
`ifndef QCC_DEFS_VH
`define QCC_DEFS_VH
// per-channel register index, byte address = ch*32 + idx*4
`define QCC_R_COUNT 3'h0
`define QCC_R_CAPIDX 3'h1
`define QCC_R_CAPTRG 3'h2
`define QCC_R_CTRL 3'h3
`define QCC_R_BPPOS 3'h4
`define QCC_R_BPPER 3'h5
`define QCC_R_STAT 3'h6
`define QCC_R_CMD 3'h7
// global registers, address bit 7 set
`define QCC_G_IRQST 3'h0
`define QCC_G_IRQMSK 3'h1
// address fields
`define QCC_A_GLB 7
`define QCC_A_CH 6:5
`define QCC_A_REG 4:2
// control register fields
`define QCC_C_TPOL 0
`define QCC_C_MODE 2:1
`define QCC_C_ACT 4:3
`define QCC_C_PREN 5
`define QCC_C_PRLV 6
`define QCC_C_W 7
// breakpoint modes and match actions
`define QCC_BPM_ABS 2'h0
`define QCC_BPM_MOD 2'h1
`define QCC_BPM_REL 2'h2
`define QCC_BPA_RISE 2'h0
`define QCC_BPA_FALL 2'h1
`define QCC_BPA_TOG 2'h2
// command register bits, write one to act
`define QCC_K_ARMT 0
`define QCC_K_FIND 1
`define QCC_K_ARMB 2
`define QCC_K_SET 3
`define QCC_K_CLR 4
// event bits inside one channel's nibble of the irq status
`define QCC_E_TRG 0
`define QCC_E_IDX 1
`define QCC_E_BP 2
`define QCC_E_ERR 3
`define QCC_ZERO 32'h0000_0000
`define QCC_ONE 32'h0000_0001
`endif

// ==== hw/qcc_top.v ====
// How it works
// - each channel keeps a 32-bit up/down count
// - leading phase picks count direction
// - all four phase edges count one step
// - one count per clock; a step in a count write cycle is lost
// - index edge during search latches count
// - armed trigger edge latches count quickly
// - trigger polarity selectable by software
// - trigger disarms after one capture
// - trigger occurrence latched and readable
// - armed breakpoint output changes on count match
// - breakpoint absolute, modulo or relative
// - breakpoint fires once per arming
// - arming presets output; match rises, falls, toggles
// - arming clears status; firing sets it
// - status read gives flags, not pin level
// - software can force breakpoint output
`timescale 1ns/10ps
`include "qcc_defs.vh"
module qcc_top #(
   parameter NCH = 4,
   parameter CW = 32
) (
   input wire core_clk,
   input wire reset,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire [NCH-1:0] enc_a,
   input wire [NCH-1:0] enc_b,
   input wire [NCH-1:0] enc_idx,
   input wire [NCH-1:0] trig_in,
   output wire [NCH-1:0] bp_out,
   output reg irq
);

   // byte-lane merge shared by every writable register
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] sel;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (sel[k]) begin
               merge[8*k +: 8] = nw[8*k +: 8];
            end
         end
      end
   endfunction

   // rising edge between the last two synchronised samples
   function rise;
      input [2:0] s;
      begin
         rise = s[1] & ~s[2];
      end
   endfunction

   // falling edge, same taps as rise
   function fall;
      input [2:0] s;
      begin
         fall = ~s[1] & s[2];
      end
   endfunction

   // write strobe for one register of the addressed channel
   function hit;
      input w;
      input [2:0] r;
      input [2:0] want;
      begin
         hit = w && r == want;
      end
   endfunction

   // a request is served once; ack drops the cycle after
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr = req & wb_we_i;
   wire glb = wb_adr_i[`QCC_A_GLB];
   wire [2:0] rsel = wb_adr_i[`QCC_A_REG];
   wire [32*NCH-1:0] ch_rd;
   wire [4*NCH-1:0] ev;
   reg [4*NCH-1:0] ist_q;
   reg [4*NCH-1:0] imsk_q;
   reg [4*NCH-1:0] ist_d;
   reg [4*NCH-1:0] imsk_d;
   reg [31:0] rd_d;
   // full-word views of a write, cut back to the event field
   wire [31:0] clrm = merge(`QCC_ZERO, wb_dat_i, wb_sel_i);
   wire [31:0] mskm = merge({{32-4*NCH{1'b0}}, imsk_q}, wb_dat_i,
      wb_sel_i);

   genvar i;
   generate
      for (i = 0; i < NCH; i = i + 1) begin : g_ch
         // [0],[1] synchroniser, [2] previous sample
         reg [2:0] a_s;
         reg [2:0] b_s;
         reg [2:0] x_s;
         reg [2:0] t_s;
         reg [CW-1:0] cnt_q;
         reg [CW-1:0] cnt_d;
         reg [CW-1:0] res_q;
         reg [CW-1:0] res_d;
         reg [CW-1:0] capx_q;
         reg [CW-1:0] capt_q;
         reg [CW-1:0] pos_q;
         reg [CW-1:0] per_q;
         reg [CW-1:0] tgt_q;
         reg [`QCC_C_W-1:0] ctl_q;
         reg tarm_q;
         reg tocc_q;
         reg srch_q;
         reg xfnd_q;
         reg barm_q;
         reg bocc_q;
         reg bp_q;
         reg [31:0] rd;
         wire me = ~glb & (wb_adr_i[`QCC_A_CH] == i);
         wire wch = wr & me;
         wire [31:0] wcmd = hit(wch, rsel, `QCC_R_CMD) ?
            merge(`QCC_ZERO, wb_dat_i, wb_sel_i) : `QCC_ZERO;
         wire ld = hit(wch, rsel, `QCC_R_COUNT);
         wire perw = hit(wch, rsel, `QCC_R_BPPER);
         wire posw = hit(wch, rsel, `QCC_R_BPPOS);
         wire ctlw = hit(wch, rsel, `QCC_R_CTRL);
         wire [31:0] ctlm = merge({25'h0, ctl_q}, wb_dat_i, wb_sel_i);
         // direction from which phase moved against the other
         wire up = (a_s[1] ^ b_s[2]) & ~(b_s[1] ^ a_s[2]);
         wire dn = (b_s[1] ^ a_s[2]) & ~(a_s[1] ^ b_s[2]);
         // both phases moving at once has no defined direction
         wire qerr = (a_s[1] ^ a_s[2]) & (b_s[1] ^ b_s[2]);
         wire xr = rise(x_s);
         // polarity picks rising or falling edge as active
         wire tact = ctl_q[`QCC_C_TPOL] ? rise(t_s) : fall(t_s);
         wire armt = wcmd[`QCC_K_ARMT];
         wire armb = wcmd[`QCC_K_ARMB];
         wire tfire = tarm_q & tact;
         wire xfire = srch_q & xr;
         wire [1:0] mode = ctl_q[`QCC_C_MODE];
         wire [1:0] act = ctl_q[`QCC_C_ACT];
         // compare against the next count so the pin moves with it
         wire match = (mode == `QCC_BPM_MOD) ?
            (res_d == pos_q) : (cnt_d == tgt_q);
         wire bfire = barm_q & ~armb & match;

         // every clock accepts one step unless the count is written; no event queue needed
         always @* begin
            cnt_d = cnt_q;
            if (ld) begin
               cnt_d = merge(cnt_q, wb_dat_i, wb_sel_i);
            end else if (up) begin
               cnt_d = cnt_q + `QCC_ONE;
            end else if (dn) begin
               cnt_d = cnt_q - `QCC_ONE;
            end
         end

         // residue follows the count, wrapping at the period
         always @* begin
            res_d = res_q;
            if (ld || perw) begin
               res_d = `QCC_ZERO;
            end else if (up) begin
               res_d = (res_q == per_q - `QCC_ONE) ?
                  `QCC_ZERO : res_q + `QCC_ONE;
            end else if (dn) begin
               res_d = (res_q == `QCC_ZERO) ?
                  per_q - `QCC_ONE : res_q - `QCC_ONE;
            end
         end

         // input synchronisers, stage 0 feeds only stage 1
         always @(posedge core_clk) begin
            if (reset) begin
               a_s <= 3'h0;
               b_s <= 3'h0;
               x_s <= 3'h0;
               t_s <= 3'h0;
            end else begin
               a_s <= {a_s[1:0], enc_a[i]};
               b_s <= {b_s[1:0], enc_b[i]};
               x_s <= {x_s[1:0], enc_idx[i]};
               t_s <= {t_s[1:0], trig_in[i]};
            end
         end

         // count and residue advance together every clock
         always @(posedge core_clk) begin
            if (reset) begin
               cnt_q <= `QCC_ZERO;
               res_q <= `QCC_ZERO;
            end else begin
               cnt_q <= cnt_d;
               res_q <= res_d;
            end
         end

         // captures; a capture never blocks a count step
         always @(posedge core_clk) begin
            if (reset) begin
               capx_q <= `QCC_ZERO;
               capt_q <= `QCC_ZERO;
            end else begin
               // trigger is synchronised as far as the phases,
               // so the count taken is the one at the edge
               if (tfire) begin
                  capt_q <= cnt_q;
               end
               if (xfire) begin
                  capx_q <= cnt_q;
               end
            end
         end

         // configuration written by software
         always @(posedge core_clk) begin
            if (reset) begin
               pos_q <= `QCC_ZERO;
               per_q <= `QCC_ZERO;
               ctl_q <= {`QCC_C_W{1'b0}};
            end else begin
               if (posw) begin
                  pos_q <= merge(pos_q, wb_dat_i, wb_sel_i);
               end
               if (perw) begin
                  per_q <= merge(per_q, wb_dat_i, wb_sel_i);
               end
               // bits above the control field are dropped
               if (ctlw) begin
                  ctl_q <= ctlm[`QCC_C_W-1:0];
               end
            end
         end

         // one-shot flags for trigger, index search, breakpoint
         always @(posedge core_clk) begin
            if (reset) begin
               tarm_q <= 1'b0;
               tocc_q <= 1'b0;
               srch_q <= 1'b0;
               xfnd_q <= 1'b0;
               barm_q <= 1'b0;
               bocc_q <= 1'b0;
               tgt_q <= `QCC_ZERO;
            end else begin
               if (armt) begin
                  tarm_q <= 1'b1;
               end else if (tfire) begin
                  tarm_q <= 1'b0;
               end
               // an edge in the arming cycle still counts
               if (tfire) begin
                  tocc_q <= 1'b1;
               end else if (armt) begin
                  tocc_q <= 1'b0;
               end
               if (wcmd[`QCC_K_FIND]) begin
                  srch_q <= 1'b1;
               end else if (xfire) begin
                  srch_q <= 1'b0;
               end
               // a find in the marker cycle keeps the capture
               if (xfire) begin
                  xfnd_q <= 1'b1;
               end else if (wcmd[`QCC_K_FIND]) begin
                  xfnd_q <= 1'b0;
               end
               if (armb) begin
                  barm_q <= 1'b1;
                  bocc_q <= 1'b0;
                  // relative target fixed from count at arming
                  tgt_q <= (mode == `QCC_BPM_REL) ?
                     cnt_q + pos_q : pos_q;
               end else if (bfire) begin
                  barm_q <= 1'b0;
                  bocc_q <= 1'b1;
               end
            end
         end

         // output pin: force beats arm preset beats match action
         always @(posedge core_clk) begin
            if (reset) begin
               bp_q <= 1'b0;
            end else if (wcmd[`QCC_K_SET]) begin
               bp_q <= 1'b1;
            end else if (wcmd[`QCC_K_CLR]) begin
               bp_q <= 1'b0;
            end else if (armb) begin
               if (ctl_q[`QCC_C_PREN]) begin
                  bp_q <= ctl_q[`QCC_C_PRLV];
               end
            end else if (bfire) begin
               case (act)
                  `QCC_BPA_RISE: bp_q <= 1'b1;
                  `QCC_BPA_FALL: bp_q <= 1'b0;
                  `QCC_BPA_TOG: bp_q <= ~bp_q;
                  default: bp_q <= bp_q;
               endcase
            end
         end

         // register read view; status holds flags, not the pin
         always @* begin
            rd = `QCC_ZERO;
            case (rsel)
               `QCC_R_COUNT: rd = cnt_q;
               `QCC_R_CAPIDX: rd = capx_q;
               `QCC_R_CAPTRG: rd = capt_q;
               `QCC_R_CTRL: rd = {25'h0, ctl_q};
               `QCC_R_BPPOS: rd = pos_q;
               `QCC_R_BPPER: rd = per_q;
               `QCC_R_STAT: rd = {26'h0, xfnd_q, srch_q, bocc_q,
                  barm_q, tocc_q, tarm_q};
               default: rd = `QCC_ZERO;
            endcase
         end

         assign ch_rd[32*i +: 32] = rd;
         assign bp_out[i] = bp_q;
         assign ev[4*i + `QCC_E_TRG] = tfire;
         assign ev[4*i + `QCC_E_IDX] = xfire;
         assign ev[4*i + `QCC_E_BP] = bfire;
         assign ev[4*i + `QCC_E_ERR] = qerr;
      end
   endgenerate

   // sticky events, write one to clear, a new event wins
   always @* begin
      ist_d = ist_q | ev;
      imsk_d = imsk_q;
      if (wr && glb && rsel == `QCC_G_IRQST) begin
         ist_d = (ist_q & ~clrm[4*NCH-1:0]) | ev;
      end
      if (wr && glb && rsel == `QCC_G_IRQMSK) begin
         imsk_d = mskm[4*NCH-1:0];
      end
   end

   // read mux; unmapped addresses answer zero
   always @* begin
      rd_d = `QCC_ZERO;
      if (!glb) begin
         rd_d = ch_rd[{wb_adr_i[`QCC_A_CH], 5'h00} +: 32];
      end else if (wb_adr_i[`QCC_A_CH] == 2'h0) begin
         if (rsel == `QCC_G_IRQST) begin
            rd_d = {16'h0, ist_q};
         end else if (rsel == `QCC_G_IRQMSK) begin
            rd_d = {16'h0, imsk_q};
         end
      end
   end

   // bus answer one cycle after the request, then released
   always @(posedge core_clk) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= `QCC_ZERO;
         ist_q <= {4*NCH{1'b0}};
         imsk_q <= {4*NCH{1'b0}};
         irq <= 1'b0;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            wb_dat_o <= rd_d;
         end
         ist_q <= ist_d;
         imsk_q <= imsk_d;
         irq <= |(ist_d & imsk_d);
      end
   end

endmodule

// ==== test/qcc_enc_model.sv ====
`timescale 1ns/10ps
module qcc_enc_model (
   output logic [3:0] enc_a,
   output logic [3:0] enc_b,
   output logic [3:0] enc_idx,
   output logic [3:0] trig_in,
   input wire core_clk
);
   logic [1:0] ph [4];
   // all pins idle low, so reset release sees no edge
   initial begin
      ph = '{2'h0, 2'h0, 2'h0, 2'h0};
      enc_a = 4'h0;
      enc_b = 4'h0;
      enc_idx = 4'h0;
      trig_in = 4'h0;
   end
   // gray walk: a quarter cycle per clock, one phase moves at a time
   task automatic move(input int ch, input int n, input bit up);
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         ph[ch] = up ? ph[ch] + 2'h1 : ph[ch] - 2'h1;
         enc_a[ch] <= ph[ch][0] ^ ph[ch][1];
         enc_b[ch] <= ph[ch][1];
      end
   endtask
   // index or trigger level, changed just after an edge
   task automatic pin(input int ch, input bit idx, input bit v);
      @(posedge core_clk);
      if (idx) enc_idx[ch] <= v;
      else trig_in[ch] <= v;
   endtask
endmodule

// ==== test/qcc_top_chk.sv ====
`timescale 1ns/10ps
`include "qcc_defs.vh"
module qcc_top_chk #(
   parameter NCH = 4,
   parameter CW = 32
) (
   input wire core_clk,
   input wire reset,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire [NCH-1:0] enc_a,
   input wire [NCH-1:0] enc_b,
   input wire [NCH-1:0] enc_idx,
   input wire [NCH-1:0] trig_in,
   input wire [NCH-1:0] bp_out,
   input wire irq
);
   // a request held while ack is high is not a new one
   wire tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire rd_t = tk & ~wb_we_i;
   wire cmd = ~wb_adr_i[7] & (wb_adr_i[4:2] == `QCC_R_CMD);
   wire fw = tk & wb_we_i & cmd & wb_sel_i[0];
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   property p_ack; tk |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("request not acked");
   property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack1: assert property (p_ack1) else $error("ack longer than one");
   property p_hold; !$past(reset) && !$past(rd_t) |-> $stable(wb_dat_o);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_zero;
      rd_t && (cmd || wb_adr_i[7] && wb_adr_i[6:3] != 4'h0)
      |=> wb_dat_o == 32'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("read should be zero");
   property p_stat;
      rd_t && !wb_adr_i[7] && wb_adr_i[4:2] == `QCC_R_STAT
      |=> wb_dat_o[31:6] == 26'h0;
   endproperty
   a_stat: assert property (p_stat) else $error("status high bits");
   property p_fhi; fw && wb_dat_i[4:3] == 2'h1
      |=> bp_out[$past(wb_adr_i[6:5])]; endproperty
   a_fhi: assert property (p_fhi) else $error("force high lost");
   property p_flo; fw && wb_dat_i[4:3] == 2'h2
      |=> !bp_out[$past(wb_adr_i[6:5])]; endproperty
   a_flo: assert property (p_flo) else $error("force low lost");
   property p_irq; tk && wb_we_i && wb_adr_i == 8'h84
      && wb_sel_i == 4'hf && wb_dat_i == 32'h0 |=> ##1 !irq; endproperty
   a_irq: assert property (p_irq) else $error("irq with mask clear");
   property p_rst; disable iff (1'b0)
      reset |=> !wb_ack_o && !irq && bp_out == '0; endproperty
   a_rst: assert property (p_rst) else $error("outputs not reset");
   c_wr: cover property (tk && wb_we_i);
   c_irq: cover property ($rose(irq));
   c_bp: cover property ($rose(bp_out[3]));
endmodule
bind qcc_top qcc_top_chk #(.NCH(NCH), .CW(CW)) i_qcc_top_chk (
   .core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx),
   .trig_in(trig_in), .bp_out(bp_out), .irq(irq));

// ==== test/tb_qcc_top.sv ====
`timescale 1ns/10ps
`include "qcc_defs.vh"
module tb_qcc_top;
   logic core_clk = 1'b0, reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0, wb_ack_o, irq;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [3:0] enc_a, enc_b, enc_idx, trig_in, bp_out;
   int errors = 0, total_checks = 0, cyc_n = 0;
   qcc_top i_qcc_top (.core_clk(core_clk), .reset(reset),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .enc_a(enc_a),
      .enc_b(enc_b), .enc_idx(enc_idx), .trig_in(trig_in),
      .bp_out(bp_out), .irq(irq));
   qcc_enc_model i_qcc_enc_model (.core_clk(core_clk), .enc_a(enc_a),
      .enc_b(enc_b), .enc_idx(enc_idx), .trig_in(trig_in));
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge core_clk) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // one classic cycle; read data taken at the ack edge
   task automatic wb(input bit we, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // no limit here; the hang guard ends a lost answer
      do begin
         @(posedge core_clk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   function automatic logic [7:0] ra(input int c, input logic [2:0] r);
      return {1'b0, c[1:0], r, 2'b00};
   endfunction
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic mv(input int c, input int n, input bit up);
      i_qcc_enc_model.move(c, n, up);
   endtask
   task automatic t_force();
      rc(ra(0, `QCC_R_CTRL), 32'h0);
      wb(1'b1, ra(0, `QCC_R_CMD), 32'h8);
      chk(bp_out[0], 1'b1);
      rc(ra(0, `QCC_R_STAT), 32'h0);
      wb(1'b1, ra(0, `QCC_R_CMD), 32'h10);
      chk(bp_out[0], 1'b0);
      rc(ra(0, `QCC_R_CMD), 32'h0);
      rc(8'h88, 32'h0);
      $display("test force done");
   endtask
   // full speed both ways, down through zero on channels 0 to 2
   task automatic t_count();
      for (int c = 0; c < 4; c++) begin
         mv(c, c + 6, 1'b1);
         mv(c, 9, 1'b0);
         wt(4);
         rc(ra(c, `QCC_R_COUNT), c - 3);
      end
      $display("test count done");
   endtask
   task automatic t_index();
      wb(1'b1, ra(1, `QCC_R_COUNT), 32'h64);
      wb(1'b1, ra(1, `QCC_R_CMD), 32'h2);
      mv(1, 7, 1'b1);
      i_qcc_enc_model.pin(1, 1'b1, 1'b1);
      mv(1, 2, 1'b1);
      wt(4);
      rc(ra(1, `QCC_R_CAPIDX), 32'h6b);
      rc(ra(1, `QCC_R_STAT), 32'h20);
      $display("test index done");
   endtask
   // steps right after the edge must not leak into the capture
   task automatic t_trig();
      wb(1'b1, ra(2, `QCC_R_COUNT), 32'h0);
      wb(1'b1, ra(2, `QCC_R_CTRL), 32'h1);
      wb(1'b1, ra(2, `QCC_R_CMD), 32'h1);
      mv(2, 4, 1'b1);
      i_qcc_enc_model.pin(2, 1'b0, 1'b1);
      mv(2, 3, 1'b1);
      i_qcc_enc_model.pin(2, 1'b0, 1'b0);
      i_qcc_enc_model.pin(2, 1'b0, 1'b1);
      wt(4);
      rc(ra(2, `QCC_R_CAPTRG), 32'h4);
      rc(ra(2, `QCC_R_STAT), 32'h2);
      wb(1'b1, ra(2, `QCC_R_CTRL), 32'h0);
      wb(1'b1, ra(2, `QCC_R_CMD), 32'h1);
      i_qcc_enc_model.pin(2, 1'b0, 1'b0);
      wt(4);
      rc(ra(2, `QCC_R_CAPTRG), 32'h7);
      chk(irq, 1'b0);
      wb(1'b1, 8'h84, 32'h100);
      wt(2);
      chk(irq, 1'b1);
      wb(1'b1, 8'h80, 32'h100);
      wt(2);
      chk(irq, 1'b0);
      rc(8'h80, 32'h20);
      wb(1'b1, 8'h84, 32'h0);
      $display("test trigger done");
   endtask
   // preset level is the opposite of what the match should leave
   task automatic t_bp(input logic [1:0] md, input logic [1:0] ac,
      input logic [31:0] cnt, input logic [31:0] pos, input int n);
      logic lv;
      lv = (ac != `QCC_BPA_RISE);
      wb(1'b1, ra(3, `QCC_R_COUNT), cnt);
      wb(1'b1, ra(3, `QCC_R_BPPER), 32'h4);
      wb(1'b1, ra(3, `QCC_R_BPPOS), pos);
      wb(1'b1, ra(3, `QCC_R_CTRL), {25'h0, lv, 1'b1, ac, md, 1'b0});
      wb(1'b1, ra(3, `QCC_R_CMD), 32'h4);
      mv(3, n - 1, 1'b1);
      wt(4);
      chk(bp_out[3], lv);
      rc(ra(3, `QCC_R_STAT), 32'h4);
      mv(3, 1, 1'b1);
      wt(4);
      chk(bp_out[3], !lv);
      rc(ra(3, `QCC_R_STAT), 32'h8);
      mv(3, 1, 1'b0);
      mv(3, 1, 1'b1);
      wt(4);
      chk(bp_out[3], !lv);
      $display("test breakpoint %0d %0d done", md, ac);
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      wt(3);
      t_force();
      t_count();
      t_index();
      t_trig();
      t_bp(`QCC_BPM_ABS, `QCC_BPA_RISE, 32'h0, 32'h5, 5);
      t_bp(`QCC_BPM_ABS, `QCC_BPA_FALL, 32'h0, 32'h5, 5);
      t_bp(`QCC_BPM_ABS, `QCC_BPA_TOG, 32'h0, 32'h5, 5);
      t_bp(`QCC_BPM_MOD, `QCC_BPA_RISE, 32'h8, 32'h1, 1);
      t_bp(`QCC_BPM_REL, `QCC_BPA_RISE, 32'ha, 32'h3, 3);
      tally_and_finish();
   end
endmodule
